// File: lpcamj_alu.sv
// combinational arithmetic/logic unit for register and immediate operations
`timescale 1ns/1ps
module lpcamj_alu (
    input wire logic [lpcamj_pkg::GPR_W-1:0] a_i,
    input wire logic [lpcamj_pkg::GPR_W-1:0] b_i,
    input wire logic [3:0] sel_i,
    output logic [lpcamj_pkg::GPR_W-1:0] result_o,
    output logic overflow_o,
    output logic valid_o
);

    logic [lpcamj_pkg::GPR_W:0] wide;

    // ------------------------------------------------------------------
    // operation select; overflow is the carry or borrow out of bit 15
    // ------------------------------------------------------------------
    always_comb
    begin
        wide = {1'b0, lpcamj_pkg::GPR_ZERO};
        result_o = lpcamj_pkg::GPR_ZERO;
        valid_o = 1'b1;
        case (sel_i)
            lpcamj_pkg::OP_ADD:
            begin
                wide = {1'b0, a_i} + {1'b0, b_i};  // RULE3
                result_o = wide[lpcamj_pkg::GPR_W-1:0];
            end
            lpcamj_pkg::OP_SUB:
            begin
                wide = {1'b0, a_i} - {1'b0, b_i};
                result_o = wide[lpcamj_pkg::GPR_W-1:0];
            end
            lpcamj_pkg::OP_AND: result_o = a_i & b_i;
            lpcamj_pkg::OP_OR: result_o = a_i | b_i;
            lpcamj_pkg::OP_MOVE: result_o = a_i;  // caller feeds the immediate in imm mode
            lpcamj_pkg::OP_SHIFT_LEFT: result_o = a_i << b_i;
            lpcamj_pkg::OP_SHIFT_RIGHT: result_o = a_i >> b_i;
            default: valid_o = 1'b0;  // RULE18
        endcase
        overflow_o = wide[lpcamj_pkg::GPR_W];  // RULE6
    end

endmodule

// File: lpcamj_core.sv
// decode and execute core: alu, loop counter, word store/load and absolute jump
// How it works
// [RULE1] four 16-bit registers, 32-bit instruction words
// [RULE2] mode zero: all operands from registers
// [RULE3] selector picks add, sub, and, or, move, shifts
// [RULE4] mode one: signed 16-bit immediate second operand
// [RULE5] immediate ops; move loads the immediate itself
// [RULE6] add and subtract update overflow flag
// [RULE7] register and immediate ops update zero flag
// [RULE8] mode two works on 8-bit loop counter
// [RULE9] loop counter: add, subtract, clear
// [RULE10] store source into low half at address
// [RULE11] stored word holds pc, five zeros, value
// [RULE12] offsets signed 10-bit, addresses in words
// [RULE13] whole-word accesses, word zero is first
// [RULE14] load copies low half into destination
// [RULE15] jump targets counted in words
// [RULE16] select bit: immediate or register target
// [RULE17] jump type: always, on zero, on overflow
// [RULE18] otherwise pc steps one; undefined codes idle
// [RULE19] flags hold outside register/immediate alu ops
`timescale 1ns/1ps
module lpcamj_core (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [lpcamj_pkg::INSTR_W-1:0] mem_rdata_i,
    input wire logic mem_ack_i,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [lpcamj_pkg::ADDR_W-1:0] mem_addr_o,
    output logic [lpcamj_pkg::INSTR_W-1:0] mem_wdata_o,
    output logic [lpcamj_pkg::ADDR_W-1:0] pc_o,
    output logic [lpcamj_pkg::GPR_W-1:0] gpr0_o,
    output logic [lpcamj_pkg::GPR_W-1:0] gpr1_o,
    output logic [lpcamj_pkg::GPR_W-1:0] gpr2_o,
    output logic [lpcamj_pkg::GPR_W-1:0] gpr3_o,
    output logic [lpcamj_pkg::LOOP_W-1:0] loop_count_o,
    output logic zero_flag_o,
    output logic overflow_flag_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    lpcamj_pkg::lpcamj_state_type state;
    lpcamj_pkg::lpcamj_state_type next_state;
    logic [lpcamj_pkg::INSTR_W-1:0] instr;
    logic [lpcamj_pkg::INSTR_W-1:0] next_instr;
    logic [lpcamj_pkg::ADDR_W-1:0] pc;
    logic [lpcamj_pkg::ADDR_W-1:0] next_pc;
    logic [lpcamj_pkg::GPR_W-1:0] gpr [lpcamj_pkg::GPR_NUM];
    logic [lpcamj_pkg::GPR_W-1:0] next_gpr [lpcamj_pkg::GPR_NUM];
    logic [lpcamj_pkg::LOOP_W-1:0] loop_count;
    logic [lpcamj_pkg::LOOP_W-1:0] next_loop_count;
    logic zero_flag;
    logic next_zero_flag;
    logic overflow_flag;
    logic next_overflow_flag;
    logic mem_req;
    logic next_mem_req;
    logic mem_we;
    logic next_mem_we;
    logic [lpcamj_pkg::ADDR_W-1:0] mem_addr;
    logic [lpcamj_pkg::ADDR_W-1:0] next_mem_addr;
    logic [lpcamj_pkg::INSTR_W-1:0] mem_wdata;
    logic [lpcamj_pkg::INSTR_W-1:0] next_mem_wdata;

    // ------------------------------------------------------------------
    // decoded fields
    // ------------------------------------------------------------------
    logic [3:0] opcode;
    logic [2:0] mode;
    logic [3:0] operation_selector;
    logic [1:0] first_source_field;
    logic [1:0] second_source_field;
    logic [1:0] dest_field;
    logic [lpcamj_pkg::GPR_W-1:0] imm_value;
    logic [lpcamj_pkg::LOOP_W-1:0] loop_imm;
    logic [lpcamj_pkg::OFFS_W-1:0] word_offset;
    logic [2:0] jump_type;
    logic jump_sel;
    logic [lpcamj_pkg::TARGET_W-1:0] immediate_target;
    logic is_alu_data;
    logic is_loop;
    logic store_word_op;
    logic load_word_op;
    logic is_jump;
    logic jump_taken;
    logic [lpcamj_pkg::GPR_W-1:0] alu_a;
    logic [lpcamj_pkg::GPR_W-1:0] alu_b;
    logic [lpcamj_pkg::GPR_W-1:0] alu_result;
    logic alu_overflow;
    logic alu_valid;

    // base register plus signed word offset, cut to the memory word address
    function automatic logic [lpcamj_pkg::ADDR_W-1:0] word_addr(
        input logic [lpcamj_pkg::GPR_W-1:0] base,
        input logic [lpcamj_pkg::OFFS_W-1:0] offs
    );
        logic [lpcamj_pkg::GPR_W-1:0] sum;
        sum = base + {{(lpcamj_pkg::GPR_W-lpcamj_pkg::OFFS_W){offs[lpcamj_pkg::OFFS_W-1]}},
            offs};  // RULE12
        return sum[lpcamj_pkg::ADDR_W-1:0];  // RULE13
    endfunction

    // field extraction from the latched instruction word
    assign opcode = instr[lpcamj_pkg::OPC_HI:lpcamj_pkg::OPC_LO];  // RULE1
    assign mode = instr[lpcamj_pkg::MODE_HI:lpcamj_pkg::MODE_LO];
    assign operation_selector = instr[lpcamj_pkg::SEL_HI:lpcamj_pkg::SEL_LO];
    assign first_source_field = instr[lpcamj_pkg::SRC1_HI:lpcamj_pkg::SRC1_LO];
    assign second_source_field = instr[lpcamj_pkg::SRC2_HI:lpcamj_pkg::SRC2_LO];
    assign dest_field = instr[lpcamj_pkg::DST_HI:lpcamj_pkg::DST_LO];
    assign imm_value = instr[lpcamj_pkg::IMM_HI:lpcamj_pkg::IMM_LO];  // RULE4
    assign loop_imm = instr[lpcamj_pkg::LIMM_HI:lpcamj_pkg::LIMM_LO];
    assign word_offset = instr[lpcamj_pkg::OFFS_HI:lpcamj_pkg::OFFS_LO];
    assign jump_type = instr[lpcamj_pkg::JTYPE_HI:lpcamj_pkg::JTYPE_LO];
    assign jump_sel = instr[lpcamj_pkg::JSEL_BIT];
    assign immediate_target = instr[lpcamj_pkg::JTGT_HI:lpcamj_pkg::JTGT_LO];  // RULE15

    // instruction class decode
    assign is_alu_data = (opcode == lpcamj_pkg::OPC_ALU)
        && ((mode == lpcamj_pkg::MODE_REG) || (mode == lpcamj_pkg::MODE_IMM));  // RULE2
    assign is_loop = (opcode == lpcamj_pkg::OPC_ALU) && (mode == lpcamj_pkg::MODE_LOOP);  // RULE8
    assign store_word_op = (opcode == lpcamj_pkg::OPC_STORE);
    assign load_word_op = (opcode == lpcamj_pkg::OPC_LOAD);
    assign is_jump = (opcode == lpcamj_pkg::OPC_JUMP) && (mode == lpcamj_pkg::MODE_JABS);

    // operand routing; immediate move bypasses the source register
    assign alu_b = (mode == lpcamj_pkg::MODE_IMM) ? imm_value : gpr[second_source_field];
    assign alu_a = ((mode == lpcamj_pkg::MODE_IMM) && (operation_selector == lpcamj_pkg::OP_MOVE))
        ? imm_value : gpr[first_source_field];  // RULE5

    // jump condition uses flags left by the last register/immediate alu op
    always_comb
    begin
        case (jump_type)
            lpcamj_pkg::JT_ALWAYS: jump_taken = is_jump;  // RULE17
            lpcamj_pkg::JT_ZERO: jump_taken = is_jump && zero_flag;
            lpcamj_pkg::JT_OVF: jump_taken = is_jump && overflow_flag;
            default: jump_taken = 1'b0;
        endcase
    end

    lpcamj_alu u_alu (
        .a_i(alu_a),
        .b_i(alu_b),
        .sel_i(operation_selector),
        .result_o(alu_result),
        .overflow_o(alu_overflow),
        .valid_o(alu_valid)
    );

    // ------------------------------------------------------------------
    // sequencer: fetch, execute, optional data access, next fetch
    // ------------------------------------------------------------------
    always_comb
    begin
        logic fetch_next;
        fetch_next = 1'b0;
        next_state = state;
        next_instr = instr;
        next_pc = pc;
        next_gpr = gpr;
        next_loop_count = loop_count;
        next_zero_flag = zero_flag;  // RULE19
        next_overflow_flag = overflow_flag;
        next_mem_req = mem_req;
        next_mem_we = mem_we;
        next_mem_addr = mem_addr;
        next_mem_wdata = mem_wdata;
        case (state)
            lpcamj_pkg::ST_START: fetch_next = 1'b1;
            lpcamj_pkg::ST_FETCH:
            begin
                if (mem_ack_i)
                begin
                    next_instr = mem_rdata_i;
                    next_mem_req = 1'b0;
                    next_state = lpcamj_pkg::ST_EXEC;
                end
            end
            lpcamj_pkg::ST_EXEC:
            begin
                next_pc = pc + lpcamj_pkg::PC_STEP;  // RULE18
                fetch_next = 1'b1;
                if (is_alu_data && alu_valid)
                begin
                    next_gpr[dest_field] = alu_result;  // RULE3
                    next_zero_flag = (alu_result == lpcamj_pkg::GPR_ZERO);  // RULE7
                    if ((operation_selector == lpcamj_pkg::OP_ADD)
                        || (operation_selector == lpcamj_pkg::OP_SUB))
                    begin
                        next_overflow_flag = alu_overflow;  // RULE6
                    end
                end
                else if (is_loop)
                begin
                    if (operation_selector == lpcamj_pkg::LOOP_INC)
                    begin
                        next_loop_count = loop_count + loop_imm;  // RULE9
                    end
                    else if (operation_selector == lpcamj_pkg::LOOP_DEC)
                    begin
                        next_loop_count = loop_count - loop_imm;
                    end
                    else if (operation_selector == lpcamj_pkg::LOOP_CLR)
                    begin
                        next_loop_count = lpcamj_pkg::LOOP_RESET;
                    end
                end
                else if (store_word_op || load_word_op)
                begin
                    // pc stays on this instruction until the data access ends
                    next_pc = pc;
                    fetch_next = 1'b0;
                    next_mem_req = 1'b1;
                    next_mem_we = store_word_op;
                    next_mem_addr = store_word_op ? word_addr(gpr[dest_field], word_offset)
                        : word_addr(gpr[first_source_field], word_offset);  // RULE12
                    next_mem_wdata = {pc, lpcamj_pkg::STORE_PAD,
                        gpr[first_source_field]};  // RULE10 RULE11
                    next_state = lpcamj_pkg::ST_DATA;
                end
                else if (jump_taken)
                begin
                    next_pc = jump_sel ? gpr[dest_field][lpcamj_pkg::ADDR_W-1:0]
                        : immediate_target[lpcamj_pkg::ADDR_W-1:0];  // RULE16
                end
            end
            lpcamj_pkg::ST_DATA:
            begin
                if (mem_ack_i)
                begin
                    if (!mem_we)
                    begin
                        next_gpr[dest_field] = mem_rdata_i[lpcamj_pkg::LOW_HALF_HI:0];  // RULE14
                    end
                    next_pc = pc + lpcamj_pkg::PC_STEP;
                    fetch_next = 1'b1;
                end
            end
            default: next_state = lpcamj_pkg::ST_START;
        endcase
        if (fetch_next)
        begin
            next_mem_req = 1'b1;
            next_mem_we = 1'b0;
            next_mem_addr = next_pc;  // RULE13
            next_state = lpcamj_pkg::ST_FETCH;
        end
    end

    // registers only; all outputs are taken from these flops
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state <= lpcamj_pkg::ST_START;
            instr <= lpcamj_pkg::INSTR_RESET;
            pc <= lpcamj_pkg::PC_RESET;
            for (int i = 0; i < lpcamj_pkg::GPR_NUM; i++)
            begin
                gpr[i] <= lpcamj_pkg::GPR_RESET;
            end
            loop_count <= lpcamj_pkg::LOOP_RESET;
            zero_flag <= 1'b0;
            overflow_flag <= 1'b0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= lpcamj_pkg::PC_RESET;
            mem_wdata <= lpcamj_pkg::INSTR_RESET;
        end
        else
        begin
            state <= next_state;
            instr <= next_instr;
            pc <= next_pc;
            gpr <= next_gpr;
            loop_count <= next_loop_count;
            zero_flag <= next_zero_flag;
            overflow_flag <= next_overflow_flag;
            mem_req <= next_mem_req;
            mem_we <= next_mem_we;
            mem_addr <= next_mem_addr;
            mem_wdata <= next_mem_wdata;
        end
    end

    assign mem_req_o = mem_req;
    assign mem_we_o = mem_we;
    assign mem_addr_o = mem_addr;
    assign mem_wdata_o = mem_wdata;
    assign pc_o = pc;
    assign gpr0_o = gpr[0];
    assign gpr1_o = gpr[1];
    assign gpr2_o = gpr[2];
    assign gpr3_o = gpr[3];
    assign loop_count_o = loop_count;
    assign zero_flag_o = zero_flag;
    assign overflow_flag_o = overflow_flag;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    logic in_exec;
    assign in_exec = (state == lpcamj_pkg::ST_EXEC);

    property p_store_word;
        @(posedge clk_i) disable iff (rst_i)
        in_exec && store_word_op |=> mem_req_o && mem_we_o
            && (mem_wdata_o == {$past(pc), lpcamj_pkg::STORE_PAD, $past(gpr[first_source_field])});
    endproperty
    a_store_word: assert property (p_store_word) else $error("store word malformed"); // RULE11

    property p_store_addr;
        @(posedge clk_i) disable iff (rst_i)
        in_exec && store_word_op |=> mem_addr_o == $past(word_addr(gpr[dest_field], word_offset));
    endproperty
    a_store_addr: assert property (p_store_addr) else $error("store address wrong"); // RULE12

    property p_load_low;
        @(posedge clk_i) disable iff (rst_i)
        (state == lpcamj_pkg::ST_DATA) && mem_ack_i && !mem_we
            |=> gpr[$past(dest_field)] == $past(mem_rdata_i[lpcamj_pkg::LOW_HALF_HI:0]);
    endproperty
    a_load_low: assert property (p_load_low) else $error("load did not take low half"); // RULE14

    property p_zero_flag;
        @(posedge clk_i) disable iff (rst_i)
        in_exec && is_alu_data && alu_valid |=> zero_flag_o == ($past(alu_result) == 16'h0000);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong"); // RULE7

    property p_overflow;
        @(posedge clk_i) disable iff (rst_i)
        in_exec && is_alu_data && (operation_selector <= lpcamj_pkg::OP_SUB)
            |=> overflow_flag_o == $past(alu_overflow);
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow flag wrong"); // RULE6

    property p_flags_hold;
        @(posedge clk_i) disable iff (rst_i)
        !(in_exec && is_alu_data) |=> $stable(zero_flag_o) && $stable(overflow_flag_o);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flags changed"); // RULE19

    property p_loop_clear;
        @(posedge clk_i) disable iff (rst_i)
        in_exec && is_loop && (operation_selector == lpcamj_pkg::LOOP_CLR) |=> loop_count_o == 8'h00;
    endproperty
    a_loop_clear: assert property (p_loop_clear) else $error("loop counter not cleared"); // RULE9

    property p_jump_imm;
        @(posedge clk_i) disable iff (rst_i)
        in_exec && jump_taken && !jump_sel
            |=> pc_o == $past(immediate_target[lpcamj_pkg::ADDR_W-1:0]) ##1 mem_addr_o == pc_o;
    endproperty
    a_jump_imm: assert property (p_jump_imm) else $error("jump target wrong"); // RULE16

    property p_step;
        @(posedge clk_i) disable iff (rst_i)
        in_exec && !jump_taken && !store_word_op && !load_word_op
            |=> (pc_o == $past(pc) + 11'h001) && (state == lpcamj_pkg::ST_FETCH);
    endproperty
    a_step: assert property (p_step) else $error("pc did not step"); // RULE18

    c_store: cover property (@(posedge clk_i) disable iff (rst_i) in_exec && store_word_op);
    c_load: cover property (@(posedge clk_i) disable iff (rst_i) in_exec && load_word_op);
    c_jump_zero: cover property (@(posedge clk_i) disable iff (rst_i)
        in_exec && jump_taken && (jump_type == lpcamj_pkg::JT_ZERO));
    c_loop: cover property (@(posedge clk_i) disable iff (rst_i) in_exec && is_loop);

endmodule

// File: lpcamj_mem_model.sv
// behavioural shared slow memory that answers the core's word requests
`timescale 1ns/1ps
module lpcamj_mem_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] lat_i,
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [lpcamj_pkg::ADDR_W-1:0] mem_addr_i,
    input wire logic [lpcamj_pkg::INSTR_W-1:0] mem_wdata_i,
    output logic mem_ack_o,
    output logic [lpcamj_pkg::INSTR_W-1:0] mem_rdata_o
);
    logic [lpcamj_pkg::INSTR_W-1:0] mem [0:2047];
    logic [3:0] wait_cnt;

    // ----------------------------------------------------------------
    // answer path
    // ----------------------------------------------------------------
    // ack after lat_i idle cycles; read data scrambles when not acking so
    // a core that samples it late sees garbage, not the last word
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mem_ack_o <= 1'b0;
            wait_cnt <= 4'h0;
            mem_rdata_o <= 32'ha5a5_5a5a;
        end
        else if (mem_req_i && !mem_ack_o && wait_cnt == lat_i)
        begin
            mem_ack_o <= 1'b1;
            wait_cnt <= 4'h0;
            if (mem_we_i)
                mem[mem_addr_i] <= mem_wdata_i;
            mem_rdata_o <= mem_we_i ? ~mem_rdata_o : mem[mem_addr_i];
        end
        else
        begin
            mem_ack_o <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o;
            if (mem_req_i && !mem_ack_o)
                wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule

// File: lpcamj_pkg.sv
// shared constants, field positions and types of the co-processor decode/execute block
package lpcamj_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int GPR_W = 16;
    localparam int GPR_NUM = 4;
    localparam int INSTR_W = 32;
    localparam int ADDR_W = 11;
    localparam int LOOP_W = 8;
    localparam int OFFS_W = 10;
    localparam int TARGET_W = 13;

    // ------------------------------------------------------------------
    // instruction field positions
    // ------------------------------------------------------------------
    localparam int OPC_HI = 31;
    localparam int OPC_LO = 28;
    localparam int MODE_HI = 27;
    localparam int MODE_LO = 25;
    localparam int SEL_HI = 24;
    localparam int SEL_LO = 21;
    localparam int IMM_HI = 19;
    localparam int IMM_LO = 4;
    localparam int LIMM_HI = 11;
    localparam int LIMM_LO = 4;
    localparam int SRC2_HI = 5;
    localparam int SRC2_LO = 4;
    localparam int SRC1_HI = 3;
    localparam int SRC1_LO = 2;
    localparam int DST_HI = 1;
    localparam int DST_LO = 0;
    localparam int OFFS_HI = 19;
    localparam int OFFS_LO = 10;
    localparam int JTYPE_HI = 24;
    localparam int JTYPE_LO = 22;
    localparam int JSEL_BIT = 21;
    localparam int JTGT_HI = 14;
    localparam int JTGT_LO = 2;
    localparam int LOW_HALF_HI = 15;

    // ------------------------------------------------------------------
    // opcodes, modes and selector codes
    // ------------------------------------------------------------------
    localparam logic [3:0] OPC_ALU = 4'h7;
    localparam logic [3:0] OPC_STORE = 4'h6;
    localparam logic [3:0] OPC_LOAD = 4'hd;
    localparam logic [3:0] OPC_JUMP = 4'h8;
    localparam logic [2:0] MODE_REG = 3'h0;
    localparam logic [2:0] MODE_IMM = 3'h1;
    localparam logic [2:0] MODE_LOOP = 3'h2;
    localparam logic [2:0] MODE_JABS = 3'h0;
    localparam logic [3:0] LOOP_INC = 4'h0;
    localparam logic [3:0] LOOP_DEC = 4'h1;
    localparam logic [3:0] LOOP_CLR = 4'h2;
    localparam logic [2:0] JT_ALWAYS = 3'h0;
    localparam logic [2:0] JT_ZERO = 3'h1;
    localparam logic [2:0] JT_OVF = 3'h2;

    typedef enum logic [3:0] {
        OP_ADD = 4'h0,
        OP_SUB = 4'h1,
        OP_AND = 4'h2,
        OP_OR = 4'h3,
        OP_MOVE = 4'h4,
        OP_SHIFT_LEFT = 4'h5,
        OP_SHIFT_RIGHT = 4'h6
    } lpcamj_op_type;

    typedef enum logic [1:0] {
        ST_START = 2'b00,
        ST_FETCH = 2'b01,
        ST_EXEC = 2'b10,
        ST_DATA = 2'b11
    } lpcamj_state_type;

    // ------------------------------------------------------------------
    // reset values and constants
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] PC_RESET = 11'h000;
    localparam logic [ADDR_W-1:0] PC_STEP = 11'h001;
    localparam logic [GPR_W-1:0] GPR_RESET = 16'h0000;
    localparam logic [LOOP_W-1:0] LOOP_RESET = 8'h00;
    localparam logic [INSTR_W-1:0] INSTR_RESET = 32'h0000_0000;
    localparam logic [4:0] STORE_PAD = 5'h00;
    localparam logic [GPR_W-1:0] GPR_ZERO = 16'h0000;

endpackage

// File: tb_top.sv
// self-checking testbench running small programs through the core
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] lat = 4'h0;
    logic ack, req, we, zf, of;
    logic [31:0] rdata, wdata;
    logic [10:0] addr, pc;
    logic [15:0] g0, g1, g2, g3;
    logic [7:0] loop_cnt;
    logic [31:0] prog [$];
    int err_count = 0;
    int checked = 0;
    int cycles = 0;

    always #50 clk_i = ~clk_i;

    lpcamj_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .mem_rdata_i(rdata), .mem_ack_i(ack),
        .mem_req_o(req), .mem_we_o(we), .mem_addr_o(addr), .mem_wdata_o(wdata), .pc_o(pc),
        .gpr0_o(g0), .gpr1_o(g1), .gpr2_o(g2), .gpr3_o(g3), .loop_count_o(loop_cnt),
        .zero_flag_o(zf), .overflow_flag_o(of));
    lpcamj_mem_model u_mem (.clk_i(clk_i), .rst_i(rst_i), .lat_i(lat), .mem_req_i(req),
        .mem_we_i(we), .mem_addr_i(addr), .mem_wdata_i(wdata), .mem_ack_o(ack),
        .mem_rdata_o(rdata));

    // ----------------------------------------------------------------
    // instruction encoders
    // ----------------------------------------------------------------
    function automatic logic [31:0] ai(logic [3:0] s, logic [15:0] i, logic [1:0] a, logic [1:0] d);
        return {4'h7, 3'h1, s, 1'b0, i, a, d};
    endfunction
    function automatic logic [31:0] ar(logic [3:0] s, logic [1:0] b, logic [1:0] a, logic [1:0] d);
        return {4'h7, 3'h0, s, 15'h0000, b, a, d};
    endfunction
    function automatic logic [31:0] lp(logic [3:0] s, logic [7:0] i);
        return {4'h7, 3'h2, s, 9'h000, i, 4'h0};
    endfunction
    function automatic logic [31:0] ls(logic [3:0] o, logic [9:0] f, logic [1:0] a, logic [1:0] d);
        return {o, 8'h00, f, 6'h00, a, d};
    endfunction
    function automatic logic [31:0] jp(logic [2:0] t, logic s, logic [12:0] g, logic [1:0] r);
        return {4'h8, 3'h0, t, s, 6'h00, g, r};
    endfunction

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // reset, load program under reset, run until the final self-jump holds
    task automatic run(input logic [3:0] l, input logic [10:0] end_pc);
        lat <= l;
        rst_i <= 1'b1;
        @(posedge clk_i);
        foreach (prog[i]) u_mem.mem[i] = prog[i];
        @(posedge clk_i);
        rst_i <= 1'b0;
        for (int n = 0; n < 600 && pc !== end_pc; n++) @(posedge clk_i);
        repeat (8) @(posedge clk_i);
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    // shifts, subtract to zero, loop counter ops, taken jump on zero
    task automatic t_alu;
        prog = '{ai(4, 16'h00f0, 3, 0), ai(4, 16'h0004, 0, 1), ar(5, 1, 0, 2), ar(6, 1, 2, 3),
            ar(1, 3, 0, 3), lp(0, 8'h07), lp(2, 8'h00), lp(0, 8'h05), jp(1, 0, 13'd10, 0),
            ai(4, 16'hdead, 0, 0), jp(0, 0, 13'd10, 0)};
        run(4'h0, 11'd10);
        chk("r0_r1", 32'h00f0_0004, {g0, g1});
        chk("r2_r3", 32'h0f00_0000, {g2, g3});
        chk("pc_loop_flags", 32'({11'd10, 8'h05, 2'b10}), 32'({pc, loop_cnt, zf, of}));
        $display("test alu done");
    endtask

    // slow memory: store with negative offset, load low half, register jump
    task automatic t_mem;
        prog = '{ai(4, 16'h1234, 0, 0), ai(4, 16'h0020, 0, 1), ls(4'h6, 10'h3ff, 0, 1),
            ai(4, 16'h0041, 0, 2), ls(4'hd, 10'h3ff, 2, 3), ar(2, 3, 0, 0), ai(4, 16'h0008, 0, 1),
            jp(0, 1, 13'd0, 1), jp(0, 0, 13'd8, 0)};
        u_mem.mem[64] = 32'habcd_5678;
        run(4'h3, 11'd8);
        chk("stored_word", 32'h0040_1234, u_mem.mem[31]);
        chk("r0_r1", 32'h1230_0008, {g0, g1});
        chk("r2_r3", 32'h0041_5678, {g2, g3});
        chk("pc_loop_flags", 32'({11'd8, 8'h00, 2'b00}), 32'({pc, loop_cnt, zf, of}));
        $display("test memory done");
    endtask

    // carry sets overflow, OR keeps it, jump types, loop underflow, bad selector
    task automatic t_flags;
        prog = '{ai(4, 16'hffff, 0, 0), ai(0, 16'h0001, 0, 1), ai(3, 16'h0000, 0, 2),
            jp(1, 0, 13'd6, 0), jp(2, 0, 13'd6, 0), ai(4, 16'hdead, 0, 3), lp(1, 8'h02),
            ar(4'hf, 0, 0, 0), jp(0, 0, 13'd8, 0)};
        run(4'h1, 11'd8);
        chk("r0_r1", 32'hffff_0000, {g0, g1});
        chk("r2_r3", 32'hffff_0000, {g2, g3});
        chk("pc_loop_flags", 32'({11'd8, 8'hfe, 2'b01}), 32'({pc, loop_cnt, zf, of}));
        $display("test flags done");
    endtask

    // ----------------------------------------------------------------
    // run control
    // ----------------------------------------------------------------
    // hang guard: three programs need well under a thousand cycles
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            give_verdict();
        end
    end

    initial
    begin
        t_alu();
        t_mem();
        t_flags();
        give_verdict();
    end
endmodule
